// *** src/bpd_defines.vh ***
`ifndef BPD_DEFINES_VH
`define BPD_DEFINES_VH

// register byte offsets
`define BPD_OFF_DATA      12'h000
`define BPD_OFF_LATCH     12'h004
`define BPD_OFF_DIR       12'h008
`define BPD_OFF_ANSEL     12'h00C
`define BPD_OFF_LCD_EN    12'h010
`define BPD_OFF_CCP_EN    12'h014
`define BPD_OFF_IN_OVR    12'h018

// reset values
`define BPD_RST_DIR       8'hFF
`define BPD_RST_LATCH     8'h00
`define BPD_RST_ANSEL     8'hFF
`define BPD_RST_EN        8'h00

// axi responses
`define BPD_RESP_OKAY     2'b00
`define BPD_RESP_SLVERR   2'b10

`endif

// *** src/bpd_pin_mux.v ***
`timescale 1ns/100ps
// per-pin output priority select
module bpd_pin_mux (
  // data sources
  input  wire [7:0] latch_val,
  input  wire [7:0] dir_in,
  input  wire [7:0] lcd_en,
  input  wire [7:0] lcd_val,
  input  wire [7:0] ccp_en,
  input  wire [7:0] ccp_val,
  input  wire [7:0] in_ovr,
  // resolved drive
  output reg  [7:0] pin_val,
  output reg  [7:0] pin_oe
);
  integer i;
  always @* begin
    pin_val = 8'h00;
    pin_oe  = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (in_ovr[i]) begin
        pin_val[i] = 1'b0;
        pin_oe[i]  = 1'b0;
      end else if (lcd_en[i]) begin
        pin_val[i] = lcd_val[i];
        pin_oe[i]  = 1'b1;
      end else if (ccp_en[i]) begin
        pin_val[i] = ccp_val[i];
        pin_oe[i]  = 1'b1;
      end else begin
        pin_val[i] = latch_val[i];
        pin_oe[i]  = ~dir_in[i];
      end
    end
  end
endmodule

// *** src/bpd_port.v ***
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "bpd_defines.vh"
module bpd_port (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // pads
  input  wire [7:0]  pin_in,
  output reg  [7:0]  pin_out,
  output reg  [7:0]  pin_oe,
  // peripheral outputs sharing the pins
  input  wire        lcd_common_three,
  input  wire [4:0]  lcd_segment_out,
  input  wire        capture_compare_four_out,
  input  wire        pwm2_steer_b,
  input  wire        pwm2_steer_c,
  input  wire        pwm2_steer_d,
  input  wire        pwm1_steer_b,
  input  wire        pwm1_steer_c,
  input  wire        pwm1_steer_d,
  // synchronised pin level to digital peripherals
  output reg  [7:0]  periph_pin_level
);
  reg        rst_s1_q;
  reg        rst_s2_q;
  wire       rst_n = rst_s2_q;

  reg  [7:0] sync1_q;
  reg  [7:0] sync2_q;
  reg  [7:0] pin_direction_bits_q;
  reg  [7:0] output_latch_bits_q;
  reg  [7:0] analog_select_bits_q;
  reg  [7:0] lcd_en_q;
  reg  [7:0] ccp_en_q;
  reg  [7:0] in_ovr_q;

  reg        aw_have_q;
  reg        w_have_q;
  reg [11:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  wire [7:0] mux_val;
  wire [7:0] mux_oe;
  wire [7:0] digital_in;
  wire [7:0] lcd_val;
  wire [7:0] ccp_val;

  // plain digital reads of analog pins return zero
  function [7:0] bpd_dig_read;
    input [7:0] lvl;
    input [7:0] ana;
    begin
      bpd_dig_read = lvl & ~ana;
    end
  endfunction

  // byte lanes below the word are ignored
  function [11:0] bpd_word_addr;
    input [11:0] a;
    begin
      bpd_word_addr = {a[11:2], 2'b00};
    end
  endfunction

  function bpd_addr_ok;
    input [11:0] a;
    begin
      bpd_addr_ok = (a[11:2] <= `BPD_OFF_IN_OVR >> 2);
    end
  endfunction

  function [7:0] bpd_merge;
    input [7:0] old;
    input [7:0] nw;
    input       en;
    begin
      bpd_merge = en ? nw : old;
    end
  endfunction

  // reset release through two stages
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // pins are async to clk_sys; second stage alone is read
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  assign digital_in = bpd_dig_read(sync2_q, analog_select_bits_q);
  assign lcd_val = {lcd_segment_out, 2'b00, lcd_common_three};
  assign ccp_val = {pwm1_steer_d, pwm1_steer_c, pwm1_steer_b, pwm2_steer_d,
                    pwm2_steer_c, pwm2_steer_b, capture_compare_four_out, 1'b0};

  bpd_pin_mux u_mux (
    .latch_val (output_latch_bits_q),
    .dir_in    (pin_direction_bits_q),
    .lcd_en    (lcd_en_q & 8'hF9),
    .lcd_val   (lcd_val),
    .ccp_en    (ccp_en_q & 8'hFE),
    .ccp_val   (ccp_val),
    .in_ovr    (in_ovr_q),
    .pin_val   (mux_val),
    .pin_oe    (mux_oe)
  );

  // registered pad drive and peripheral input view
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_out          <= 8'h00;
      pin_oe           <= 8'h00;
      periph_pin_level <= 8'h00;
    end else begin
      pin_out          <= mux_val;
      pin_oe           <= mux_oe;
      periph_pin_level <= sync2_q;
    end
  end

  wire       wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [7:0] wb      = w_data_q[7:0];
  wire       we      = w_strb_q[0];
  wire       wr_hit  = wr_go && we;
  wire       aw_take = s_axi_awvalid && s_axi_awready;
  wire       w_take  = s_axi_wvalid && s_axi_wready;
  wire       ar_take = s_axi_arvalid && s_axi_arready;

  reg  [7:0] pin_direction_bits_d;
  reg  [7:0] output_latch_bits_d;
  reg  [7:0] analog_select_bits_d;
  reg  [7:0] lcd_en_d;
  reg  [7:0] ccp_en_d;
  reg  [7:0] in_ovr_d;
  reg  [7:0] rd_byte_d;

  // write address: held until paired with data, either order
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 12'h000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  // write data
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response stands until taken
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BPD_RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= bpd_addr_ok(aw_addr_q) ? `BPD_RESP_OKAY : `BPD_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // next register values; unmapped words change nothing
  always @* begin
    pin_direction_bits_d = pin_direction_bits_q;
    output_latch_bits_d  = output_latch_bits_q;
    analog_select_bits_d = analog_select_bits_q;
    lcd_en_d             = lcd_en_q;
    ccp_en_d             = ccp_en_q;
    in_ovr_d             = in_ovr_q;
    if (wr_hit) begin
      case (bpd_word_addr(aw_addr_q))
        // a byte write modifies every bit, so no sampled level survives
        `BPD_OFF_DATA:   output_latch_bits_d  = bpd_merge(digital_in, wb, 1'b1);
        `BPD_OFF_LATCH:  output_latch_bits_d  = wb;
        `BPD_OFF_DIR:    pin_direction_bits_d = wb;
        `BPD_OFF_ANSEL:  analog_select_bits_d = wb;
        `BPD_OFF_LCD_EN: lcd_en_d             = wb;
        `BPD_OFF_CCP_EN: ccp_en_d             = wb;
        `BPD_OFF_IN_OVR: in_ovr_d             = wb;
        default:         output_latch_bits_d  = output_latch_bits_q;
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_direction_bits_q <= `BPD_RST_DIR;
    end else begin
      pin_direction_bits_q <= pin_direction_bits_d;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      output_latch_bits_q <= `BPD_RST_LATCH;
    end else begin
      output_latch_bits_q <= output_latch_bits_d;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      analog_select_bits_q <= `BPD_RST_ANSEL;
    end else begin
      analog_select_bits_q <= analog_select_bits_d;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lcd_en_q <= `BPD_RST_EN;
    end else begin
      lcd_en_q <= lcd_en_d;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ccp_en_q <= `BPD_RST_EN;
    end else begin
      ccp_en_q <= ccp_en_d;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_ovr_q <= `BPD_RST_EN;
    end else begin
      in_ovr_q <= in_ovr_d;
    end
  end

  // read byte select
  always @* begin
    case (bpd_word_addr(s_axi_araddr))
      `BPD_OFF_DATA:   rd_byte_d = digital_in;
      `BPD_OFF_LATCH:  rd_byte_d = output_latch_bits_q;
      `BPD_OFF_DIR:    rd_byte_d = pin_direction_bits_q;
      `BPD_OFF_ANSEL:  rd_byte_d = analog_select_bits_q;
      `BPD_OFF_LCD_EN: rd_byte_d = lcd_en_q;
      `BPD_OFF_CCP_EN: rd_byte_d = ccp_en_q;
      `BPD_OFF_IN_OVR: rd_byte_d = in_ovr_q;
      default:         rd_byte_d = 8'h00;
    endcase
  end

  // read channel
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BPD_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= bpd_addr_ok(s_axi_araddr) ? `BPD_RESP_OKAY : `BPD_RESP_SLVERR;
        s_axi_rdata  <= {24'h00_0000, rd_byte_d};
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// *** verif/bpd_port_checker.sv ***
`timescale 1ns/100ps
module bpd_port_checker (
  // clock
  input wire        clk_sys,
  input wire        rst_b,
  // bus
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  // pads
  input wire [7:0]  pin_in,
  input wire [7:0]  pin_oe,
  input wire [7:0]  periph_pin_level
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  wr_answer_a: assert property (s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("no write answer");
  rd_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  bad_read_a: assert property (s_axi_arready && s_axi_araddr[11:2] > 10'h006 |=>
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
  byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper bits set");
  oe_write_a: assert property ($changed(pin_oe) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("oe moved");
  // sync depth plus reset release fits well inside eight samples
  pin_sync_a: assert property ($stable(pin_in) [*8] |-> periph_pin_level == pin_in)
    else $error("pin level lost");
  reset_idle_a: assert property (disable iff (1'b0) !rst_b |->
    pin_oe == 8'h00 && !s_axi_bvalid && !s_axi_rvalid) else $error("busy in reset");
endmodule
bind bpd_port bpd_port_checker chk_u (.*);

// *** verif/bpd_pad_model.sv ***
`timescale 1ns/100ps
module bpd_pad_model #(
  parameter [7:0] EXT_LVL = 8'h5a
) (
  // pads
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  output wire [7:0] pin_in
);
  // released pins show the outside driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & EXT_LVL);
endmodule

// *** verif/test_bidirectional_port_d_pins.sv ***
`timescale 1ns/100ps
`include "bpd_defines.vh"
module test_bidirectional_port_d_pins;
  typedef struct packed {logic [11:0] a; logic [7:0] d, oe, out, rd;} bpd_row_t;
  logic        clk_sys = 1'b0, rst_b = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, q;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  r;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [12:0] per = 13'h1aeb;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [7:0]   pin_in, pin_out, pin_oe, periph_pin_level;
  wire [4:0]   lcd_segment_out;
  wire         lcd_common_three, capture_compare_four_out, pwm2_steer_b, pwm2_steer_c;
  wire         pwm2_steer_d, pwm1_steer_b, pwm1_steer_c, pwm1_steer_d;
  int          failures = 0, comparisons = 0;
  // address, data, oe, driven out, data read
  bpd_row_t    rows [8] = '{
    '{12'h00c, 8'h00, 8'h00, 8'h00, 8'h5a},
    '{12'h000, 8'h0f, 8'h00, 8'h00, 8'h5a},
    '{12'h008, 8'hf0, 8'h0f, 8'h0f, 8'h5f},
    '{12'h00c, 8'h03, 8'h0f, 8'h0f, 8'h5c},
    '{12'h014, 8'hfe, 8'hff, 8'hd7, 8'hd4},
    '{12'h010, 8'hf9, 8'hff, 8'haf, 8'hac},
    '{12'h018, 8'h81, 8'h7e, 8'h2e, 8'h2c},
    '{12'h018, 8'h00, 8'hff, 8'haf, 8'hac}};
  assign {lcd_common_three, lcd_segment_out, capture_compare_four_out, pwm2_steer_b,
    pwm2_steer_c, pwm2_steer_d, pwm1_steer_b, pwm1_steer_c, pwm1_steer_d} = per;
  bpd_port dut_u (.*);
  bpd_pad_model pad_u (.*);
  always #10 clk_sys = ~clk_sys;
  task ck(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one task for both directions keeps the handshake identical
  task bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 50);
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n >= 50) begin
      failures++;
      test_done;
    end
  endtask
  initial begin
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, `BPD_OFF_DIR, 8'h00);
    ck(q, 32'h0000_00ff);
    bus(1'b0, `BPD_OFF_ANSEL, 8'h00);
    ck(q, 32'h0000_00ff);
    bus(1'b0, 12'h01c, 8'h00);
    ck(r, `BPD_RESP_SLVERR);
    bus(1'b1, 12'h020, 8'hff);
    ck(r, `BPD_RESP_SLVERR);
    $display("test reset map done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      repeat (6) @(posedge clk_sys);
      bus(1'b0, `BPD_OFF_DATA, 8'h00);
      ck(pin_oe, rows[i].oe);
      ck(pin_out & pin_oe, rows[i].out);
      ck(q, rows[i].rd);
      ck(periph_pin_level, rows[i].out | (~rows[i].oe & 8'h5a));
    end
    $display("test rows done");
    bus(1'b0, `BPD_OFF_LATCH, 8'h00);
    ck(q, 32'h0000_000f);
    per <= 13'h0514;
    repeat (6) @(posedge clk_sys);
    ck(pin_out, 8'h50);
    $display("test periph flip done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, `BPD_OFF_ANSEL, 8'h00);
    ck(q, 32'h0000_00ff);
    $display("test second reset done");
    test_done;
  end
endmodule
